//--- design/cifpr_flag_bank.sv
// Sticky event flags: hardware sets, software clears, set wins
`timescale 1ns/1ns
`default_nettype none
module cifpr_flag_bank #(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // Set, clear and state
  cifpr_flag_if.bank  fb
);

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb.flag <= '0;
    end else begin
      fb.flag <= (fb.flag & ~fb.clr) | fb.set;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|fb.set) |=> ((fb.flag & $past(fb.set)) == $past(fb.set)))
    else $error("flag set lost against clear");

  clr_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(fb.clr & ~fb.set)) |=> ((fb.flag & $past(fb.clr & ~fb.set)) == '0))
    else $error("flag not cleared");

  hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fb.set == '0 && fb.clr == '0) |=> $stable(fb.flag))
    else $error("flag changed without cause");

endmodule
`default_nettype wire

//--- design/cifpr_flag_if.sv
// Carrier between the register logic and the flag bank
`timescale 1ns/1ns
`default_nettype none
interface cifpr_flag_if #(parameter int N = 8);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] flag;
  modport bank (input set, input clr, output flag);
  modport ctrl (output set, output clr, input flag);
endinterface
`default_nettype wire

//--- design/cifpr_pkg.sv
// Constants for the clock flag and peripheral reset block
package cifpr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] INT_OFFSET = 12'h008;
  localparam logic [11:0] RST_OFFSET = 12'h00c;
  localparam logic [11:0] MON_OFFSET = 12'h040;

  // ----------------------------------------
  // Clock interrupt register layout
  // ----------------------------------------
  localparam int NFLAG       = 8;
  localparam int F_INT40K    = 0;
  localparam int F_LS_STB    = 1;
  localparam int F_INT8M     = 2;
  localparam int F_HS_STB    = 3;
  localparam int F_PLL_STB   = 4;
  localparam int F_LS_STUCK  = 5;
  localparam int F_PLL_STUCK = 6;
  localparam int F_HS_STUCK  = 7;
  localparam int NEN         = 7;
  localparam int EN_LSB      = 8;
  localparam int EN_INT40K   = 0;
  localparam int EN_LS       = 1;
  localparam int EN_INT8M    = 2;
  localparam int EN_HS       = 3;
  localparam int EN_PLL      = 4;
  localparam int CLR_LSB     = 16;
  localparam int MON_NMI     = 0;
  localparam logic [31:0] INT_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Peripheral reset register layout
  // ----------------------------------------
  localparam int RB_CFG    = 0;
  localparam int RB_CMP    = 1;
  localparam int RB_ADCA   = 9;
  localparam int RB_ADCB   = 10;
  localparam int RB_TMR0   = 11;
  localparam int RB_SPI0   = 12;
  localparam int RB_TMR7   = 13;
  localparam int RB_USART0 = 14;
  localparam int RB_ADV19  = 20;
  localparam int RB_ADV20  = 21;
  localparam int RB_CANA   = 30;
  localparam int RB_CANB   = 31;
  localparam logic [31:0] RST_MASK  = 32'hc030_7e03;
  localparam logic [31:0] RST_RESET = 32'h0000_0000;

endpackage

//--- design/cifpr_top.sv
// Clock stabilization and monitor flags with peripheral reset register
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module cifpr_top
  import cifpr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Clock monitor detections
  input  wire logic              hs_crystal_stuck_det,
  input  wire logic              pll_stuck_det,
  input  wire logic              ls_crystal_stuck_det,
  // Oscillator stable indications
  input  wire logic              pll_stable,
  input  wire logic              hs_crystal_stable,
  input  wire logic              int8m_osc_stable,
  input  wire logic              ls_crystal_stable,
  input  wire logic              int40k_osc_stable,
  // Clock monitor control
  output logic                   clock_monitor_nmi_enable,
  // Peripheral reset holds
  output logic                   can_ctrl_b_reset,
  output logic                   can_ctrl_a_reset,
  output logic                   adv_timer_twenty_reset,
  output logic                   adv_timer_nineteen_reset,
  output logic                   serial_port_zero_reset,
  output logic                   timer_seven_reset,
  output logic                   spi_zero_reset,
  output logic                   timer_zero_reset,
  output logic                   converter_b_reset,
  output logic                   converter_a_reset,
  output logic                   comparator_reset,
  output logic                   sys_config_reset
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  s);
    return (old & ~lane_mask(s)) | (wd & lane_mask(s));
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0]       off);
    return a[11:0] == off;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0]    rst_reg;
  logic [NEN-1:0] int_en;
  logic [NFLAG-1:0] raw_evt;
  logic [NFLAG-1:0] sync1;
  logic [NFLAG-1:0] sync2;
  logic [NFLAG-1:0] prev;
  logic [NFLAG-1:0] evt_rise;
  logic [NFLAG-1:0] evt_gate;
  logic [NFLAG-1:0] next_clr;
  logic [31:0]    wmask;
  logic           access;
  logic           wr_int;
  logic           wr_rst;
  logic           wr_mon;
  logic           nmi_set_wr;
  logic           mapped;

  cifpr_flag_if #(.N(NFLAG)) fi ();

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign access = psel && penable && pready;
  assign mapped = hit(paddr, INT_OFFSET) || hit(paddr, RST_OFFSET) ||
                  hit(paddr, MON_OFFSET);
  assign wr_int = access && pwrite && hit(paddr, INT_OFFSET);
  assign wr_rst = access && pwrite && hit(paddr, RST_OFFSET);
  assign wr_mon = access && pwrite && hit(paddr, MON_OFFSET);
  assign wmask  = lane_mask(pstrb);

  // Answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !mapped;
    end
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      if (pwrite || !mapped) begin
        prdata <= '0;
      end else if (hit(paddr, INT_OFFSET)) begin
        prdata <= INT_RESET | {17'h0_0000, int_en, fi.flag};
      end else if (hit(paddr, RST_OFFSET)) begin
        prdata <= rst_reg;
      end else begin
        prdata <= {31'h0000_0000, clock_monitor_nmi_enable};
      end
    end
  end

  // ----------------------------------------
  // Enables
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en <= '0;
    end else if (wr_int) begin
      int_en <= (pwdata[EN_LSB +: NEN] & wmask[EN_LSB +: NEN]) |
                (int_en & ~wmask[EN_LSB +: NEN]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_monitor_nmi_enable <= 1'b0;
    end else if (wr_mon && pstrb[0]) begin
      clock_monitor_nmi_enable <= pwdata[MON_NMI];
    end
  end

  // ----------------------------------------
  // Event capture
  // ----------------------------------------
  assign raw_evt = {hs_crystal_stuck_det, pll_stuck_det,
                    ls_crystal_stuck_det, pll_stable,
                    hs_crystal_stable, int8m_osc_stable,
                    ls_crystal_stable, int40k_osc_stable};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= raw_evt;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign evt_rise = sync2 & ~prev;
  // Monitor flags set unconditionally, stable flags need their enable
  assign evt_gate = {3'b111, int_en[EN_PLL], int_en[EN_HS],
                     int_en[EN_INT8M], int_en[EN_LS],
                     int_en[EN_INT40K]};
  assign fi.set = evt_rise & evt_gate;

  // ----------------------------------------
  // Flag clears
  // ----------------------------------------
  assign nmi_set_wr = wr_mon && pstrb[0] && pwdata[MON_NMI];

  always_comb begin
    next_clr = '0;
    if (wr_int && pstrb[2]) begin
      next_clr = pwdata[CLR_LSB +: NFLAG];
    end
    if (nmi_set_wr) begin
      next_clr[F_HS_STUCK] = 1'b1;
    end
  end
  assign fi.clr = next_clr;

  cifpr_flag_bank #(.N(NFLAG)) u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .fb      (fi)
  );

  // ----------------------------------------
  // Peripheral reset register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_reg <= RST_RESET;
    end else if (wr_rst) begin
      rst_reg <= merge(rst_reg, pwdata, pstrb) & RST_MASK;
    end
  end

  assign can_ctrl_b_reset         = rst_reg[RB_CANB];
  assign can_ctrl_a_reset         = rst_reg[RB_CANA];
  assign adv_timer_twenty_reset   = rst_reg[RB_ADV20];
  assign adv_timer_nineteen_reset = rst_reg[RB_ADV19];
  assign serial_port_zero_reset   = rst_reg[RB_USART0];
  assign timer_seven_reset        = rst_reg[RB_TMR7];
  assign spi_zero_reset           = rst_reg[RB_SPI0];
  assign timer_zero_reset         = rst_reg[RB_TMR0];
  assign converter_b_reset        = rst_reg[RB_ADCB];
  assign converter_a_reset        = rst_reg[RB_ADCA];
  assign comparator_reset         = rst_reg[RB_CMP];
  assign sys_config_reset         = rst_reg[RB_CFG];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence int40k_up_s;
    $rose(int40k_osc_stable) ##1 int40k_osc_stable
      ##1 (int40k_osc_stable && int_en[EN_INT40K]);
  endsequence

  sequence hs_stuck_up_s;
    $rose(hs_crystal_stuck_det) ##1 hs_crystal_stuck_det
      ##1 (hs_crystal_stuck_det && !fi.clr[F_HS_STUCK]);
  endsequence

  apb_answer_a: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("answer not one cycle after setup");

  apb_unmapped_a: assert property (
    (psel && !penable && !mapped) |=> (pready && pslverr))
    else $error("unmapped access not flagged");

  int8m_en_a: assert property (
    (wr_int && pstrb[1]) |=> (int_en[EN_INT8M] == $past(pwdata[EN_LSB + EN_INT8M])))
    else $error("8 MHz enable not written");

  ls_en_a: assert property (
    (wr_int && pstrb[1]) |=> (int_en[EN_LS] == $past(pwdata[EN_LSB + EN_LS])))
    else $error("low-speed enable not written");

  int40k_en_a: assert property (
    (wr_int && pstrb[1]) |=> (int_en[EN_INT40K] == $past(pwdata[EN_LSB + EN_INT40K])))
    else $error("40 kHz enable not written");

  hs_stuck_set_a: assert property (
    hs_stuck_up_s |=> fi.flag[F_HS_STUCK])
    else $error("high-speed stuck flag not set");

  hs_stuck_clr_a: assert property (
    (wr_int && pstrb[2] && pwdata[CLR_LSB + F_HS_STUCK] && !fi.set[F_HS_STUCK])
      |=> !fi.flag[F_HS_STUCK])
    else $error("high-speed stuck clear failed");

  nmi_clr_a: assert property (
    (nmi_set_wr && !fi.set[F_HS_STUCK]) |=> !fi.flag[F_HS_STUCK])
    else $error("nmi enable did not clear flag");

  pll_stuck_a: assert property (
    evt_rise[F_PLL_STUCK] |=> fi.flag[F_PLL_STUCK])
    else $error("pll stuck flag not set");

  ls_stuck_a: assert property (
    evt_rise[F_LS_STUCK] |=> fi.flag[F_LS_STUCK])
    else $error("low-speed stuck flag not set");

  pll_stb_off_a: assert property (
    (evt_rise[F_PLL_STB] && !int_en[EN_PLL] && !fi.flag[F_PLL_STB])
      |=> !fi.flag[F_PLL_STB])
    else $error("pll stable flag set while disabled");

  hs_stb_a: assert property (
    (evt_rise[F_HS_STB] && int_en[EN_HS]) |=> fi.flag[F_HS_STB])
    else $error("high-speed stable flag not set");

  int8m_stb_a: assert property (
    (evt_rise[F_INT8M] && int_en[EN_INT8M]) |=> fi.flag[F_INT8M])
    else $error("8 MHz stable flag not set");

  ls_stb_a: assert property (
    (wr_int && pstrb[2] && pwdata[CLR_LSB + F_LS_STB] && !fi.set[F_LS_STB])
      |=> !fi.flag[F_LS_STB])
    else $error("low-speed stable clear failed");

  int40k_stb_a: assert property (
    int40k_up_s |=> fi.flag[F_INT40K])
    else $error("40 kHz stable flag not set");

  rst_lane_a: assert property (
    (wr_rst && pstrb == 4'h1) |=> (rst_reg[31:8] == $past(rst_reg[31:8])))
    else $error("unaddressed lane changed");

  rst_zero_a: assert property (
    $rose(presetn) |-> (rst_reg == RST_RESET))
    else $error("reset register not zero");

  rst_hold_a: assert property (
    !wr_rst |=> $stable(rst_reg))
    else $error("reset register changed without write");

  adv20_a: assert property (
    (wr_rst && pstrb[2] && pwdata[RB_ADV20]) |=> adv_timer_twenty_reset)
    else $error("timer twenty hold not set");

  adv19_a: assert property (
    (wr_rst && pstrb[2] && !pwdata[RB_ADV19]) |=> !adv_timer_nineteen_reset)
    else $error("timer nineteen hold not released");

  rst_resv_a: assert property (
    (rst_reg & ~RST_MASK) == '0)
    else $error("reserved reset bit set");

  cfg_hold_a: assert property (
    (wr_rst && pstrb[0] && pwdata[RB_CFG]) |=> sys_config_reset[*2])
    else $error("configuration hold not set");

endmodule
`default_nettype wire

//--- test/cifpr_top_tb.sv
// Self-checking bench for the clock flag and peripheral reset block
`timescale 1ns/1ns
`default_nettype none
module cifpr_top_tb
  import cifpr_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rst_m, rnd, d;
  logic [3:0]  pstrb;
  logic [7:0]  ev;
  logic [6:0]  en;
  logic [7:0]  fl;
  logic        clock_monitor_nmi_enable, can_ctrl_b_reset, can_ctrl_a_reset;
  logic        adv_timer_twenty_reset, adv_timer_nineteen_reset, serial_port_zero_reset;
  logic        timer_seven_reset, spi_zero_reset, timer_zero_reset, converter_b_reset;
  logic        converter_a_reset, comparator_reset, sys_config_reset;
  logic [32:0] expq [$];
  logic [32:0] pinq [$];
  logic        nmi_m;
  int          failures, check_count, cyc;
  localparam logic [3:0] STRBS [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};

  // Event sources: 0..4 stable indications, 5 ls stuck, 6 pll stuck, 7 hs stuck
  cifpr_top cifpr_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr,
    .hs_crystal_stuck_det(ev[7]), .pll_stuck_det(ev[6]), .ls_crystal_stuck_det(ev[5]),
    .pll_stable(ev[4]), .hs_crystal_stable(ev[3]), .int8m_osc_stable(ev[2]),
    .ls_crystal_stable(ev[1]), .int40k_osc_stable(ev[0]),
    .clock_monitor_nmi_enable, .can_ctrl_b_reset, .can_ctrl_a_reset,
    .adv_timer_twenty_reset, .adv_timer_nineteen_reset, .serial_port_zero_reset,
    .timer_seven_reset, .spi_zero_reset, .timer_zero_reset, .converter_b_reset,
    .converter_a_reset, .comparator_reset, .sys_config_reset
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] int_val();
    return {16'h0000, 1'b0, en, fl};
  endfunction

  function automatic logic [31:0] rst_pins();
    return {can_ctrl_b_reset, can_ctrl_a_reset, 8'h00, adv_timer_twenty_reset,
            adv_timer_nineteen_reset, 5'h00, serial_port_zero_reset, timer_seven_reset,
            spi_zero_reset, timer_zero_reset, converter_b_reset, converter_a_reset,
            7'h00, comparator_reset, sys_config_reset};
  endfunction

  task automatic cmp_apb(input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] apb_resp expected %h seen %h", e, g);
    end
  endtask

  task automatic cmp_pins(input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] nmi_and_reset_pins expected %h seen %h", e, g);
    end
  endtask

  task automatic close_out();
    if (expq.size() != 0 || pinq.size() != 0) begin
      failures++;
      $display("[ERR] note_queue expected 0 seen %0d", expq.size() + pinq.size());
    end
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One APB transfer; the expected answer goes to the note queue
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] s, input logic [32:0] e);
    expq.push_back(e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 4'hf, 33'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hf, {1'b0, e});
  endtask

  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    repeat (4) @(posedge pclk);
    ev[i] <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask

  // Expected nmi enable and reset holds; compared at the next falling edge
  task automatic pins(input logic [31:0] e);
    pinq.push_back({nmi_m, e});
    @(negedge pclk);
  endtask

  // ----------------------------------------
  // Clock, timeout and response monitor
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (expq.size() == 0) begin
        failures++;
        $display("[ERR] apb_note expected entry seen none");
      end else begin
        cmp_apb(expq.pop_front(), {pslverr, prdata});
      end
    end
  end

  always @(negedge pclk) begin
    if (pinq.size() > 0) begin
      cmp_pins(pinq.pop_front(), {clock_monitor_nmi_enable, rst_pins()});
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, ev} = '0;
    {failures, check_count, cyc} = '0;
    presetn = 1'b0;
    en = '0;
    fl = '0;
    rst_m = '0;
    nmi_m = 1'b0;
    rnd = 32'hba0c80ae;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    pins(32'h0);
    rd(RST_OFFSET, 32'h0);
    rd(INT_OFFSET, 32'h0);
    en = 7'h7f;
    wr(INT_OFFSET, int_val());
    rd(INT_OFFSET, int_val());
    en = 7'h00;
    wr(INT_OFFSET, int_val());
    for (int i = 0; i < 8; i++) begin
      if (i < 5) begin
        pulse(i);
        rd(INT_OFFSET, int_val());
        en[i] = 1'b1;
        wr(INT_OFFSET, int_val());
      end
      pulse(i);
      fl[i] = 1'b1;
      rd(INT_OFFSET, int_val());
      wr(INT_OFFSET, {16'h0000, 1'b0, en, 8'h00});
      rd(INT_OFFSET, int_val());
      wr(INT_OFFSET, (32'h1 << (16 + i)) | {16'h0000, 1'b0, en, 8'h00});
      fl[i] = 1'b0;
      rd(INT_OFFSET, int_val());
    end
    pulse(7);
    fl[7] = 1'b1;
    rd(INT_OFFSET, int_val());
    wr(MON_OFFSET, 32'h1);
    fl[7] = 1'b0;
    nmi_m = 1'b1;
    pins(rst_m);
    rd(INT_OFFSET, int_val());
    rd(MON_OFFSET, 32'h1);
    apb(1'b0, 12'h100, 32'h0, 4'hf, {1'b1, 32'h0});
    apb(1'b1, 12'h104, 32'hffffffff, 4'hf, {1'b1, 32'h0});
    pins(32'h0);
    repeat (6) begin
      rnd = lfsr(rnd);
      d = rnd & RST_MASK;
      wr(RST_OFFSET, d);
      rst_m = d;
      pins(rst_m);
      rd(RST_OFFSET, rst_m);
    end
    for (int k = 0; k < 7; k++) begin
      rnd = lfsr(rnd);
      d = rnd & RST_MASK;
      apb(1'b1, RST_OFFSET, d, STRBS[k], 33'h0);
      for (int b = 0; b < 4; b++) begin
        if (STRBS[k][b]) begin
          rst_m[8*b +: 8] = d[8*b +: 8];
        end
      end
      pins(rst_m);
      rd(RST_OFFSET, rst_m);
    end
    pulse(7);
    pulse(4);
    pins(rst_m);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    {en, fl, rst_m, nmi_m} = '0;
    pins(32'h0);
    rd(RST_OFFSET, 32'h0);
    rd(INT_OFFSET, int_val());
    repeat (3) @(posedge pclk);
    close_out();
  end
endmodule
`default_nettype wire
